/* File: rtl/hpmb_cfg.svh */
// constants for the host port mailbox and status block
// Function
// - cpu message write sets flag, raises pin
// - host read clears engine message flags
// - host mailbox write raises cpu receive interrupt
// - host mailbox read raises cpu transmit interrupt
// - cpu mailbox write raises pin until host reads mailbox
// - one shared 16-bit mailbox word, reset zero
// - status word readable by host only
// - status read makes no memory cycle
// - bit 15 shows bus supply above threshold
// - bit 14 follows identity pin level
// - bits 12 and 10 show frame events
// - bits 9 and 1 show bus resets
// - bit 8 shows host message awaiting cpu
// - bits 7 and 6 show wakeup events
// - bits 3 and 2 show port completion
// - bit 0 shows cpu message awaiting host
// - engine interrupt visible only when routed
`ifndef HPMB_CFG_SVH
`define HPMB_CFG_SVH
// word addresses seen by cpu and host
`define HPMB_MBX_ADDR 16'hC0C6
`define HPMB_MSG1_ADDR 16'h0144
`define HPMB_MSG2_ADDR 16'h0148
`define HPMB_MBX_RESET 16'h0000
// status word bit positions
`define HPMB_ST_VBUS 15
`define HPMB_ST_ID 14
`define HPMB_ST_FRM2 12
`define HPMB_ST_FRM1 10
`define HPMB_ST_RST2 9
`define HPMB_ST_MBX_IN 8
`define HPMB_ST_WAKE2 7
`define HPMB_ST_WAKE1 6
`define HPMB_ST_MSG2 5
`define HPMB_ST_MSG1 4
`define HPMB_ST_DONE2 3
`define HPMB_ST_DONE1 2
`define HPMB_ST_RST1 1
`define HPMB_ST_MBX_OUT 0
// routing enable positions; vbus and id match status positions, the two frame enables differ
`define HPMB_RT_VBUS 15
`define HPMB_RT_ID 14
`define HPMB_RT_FRM2 13
`define HPMB_RT_FRM1 11
// engine flags carried in the status word
`define HPMB_ENG_MASK 16'h16CE
`endif

/* File: rtl/hpmb_pin_if.sv */
// interface carrying raw pin levels and their synchronised copies
`timescale 1ns/100ps
interface hpmb_pin_if #(parameter int W = 2);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

/* File: rtl/hpmb_pkg.sv */
// types for the host port mailbox and status block
package hpmb_pkg;
  typedef logic [15:0] hpmb_word_t;
  // target of a decoded access
  typedef enum logic [1:0] {TGT_NONE, TGT_MBX, TGT_MSG1, TGT_MSG2} hpmb_tgt_t;
endpackage

/* File: rtl/hpmb_sync.sv */
// three stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module hpmb_sync #(parameter int W = 2) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins in, clean levels out
  hpmb_pin_if.sync pins
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] clean_ff;

  // first stage only feeds the second, guarding against metastability
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pins.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit moves only once two later stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clean_ff <= '0;
    end else begin
      clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
    end
  end

  assign pins.clean = clean_ff;
endmodule

/* File: rtl/hpmb_top.sv */
// mailbox, engine message flags and host status port
`timescale 1ns/100ps
`include "hpmb_cfg.svh"
module hpmb_top import hpmb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // on-chip cpu access, one-cycle strobes
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  // cpu mailbox interrupts and their enables
  input wire logic mbx_rx_irq_en,
  input wire logic mbx_tx_irq_en,
  output logic mbx_rx_irq,
  output logic mbx_tx_irq,
  // parallel host port, decoded one-cycle strobes
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_stat_rd,
  output logic [15:0] host_rdata,
  output logic host_mem_req,
  output logic host_interrupt_pin,
  // engine interrupt levels and routing enables
  input wire logic [15:0] eng_irq,
  input wire logic [15:0] route_en,
  // otg pins
  input wire logic vbus_above_pin,
  input wire logic otg_id_pin
);
  hpmb_word_t mbx_ff;
  logic in_full_ff;
  logic out_full_ff;
  logic msg1_ff;
  logic msg2_ff;
  logic otg_chg_ff;
  logic [1:0] otg_prev_ff;
  logic rx_irq_ff;
  logic tx_irq_ff;
  logic intr_ff;
  logic mem_req_ff;
  hpmb_word_t cpu_rdata_ff;
  hpmb_word_t host_rdata_ff;
  hpmb_tgt_t cpu_tgt;
  hpmb_tgt_t host_tgt;
  hpmb_word_t route_vec;
  hpmb_word_t eng_vis;
  hpmb_word_t stat_word;
  logic vbus_lvl;
  logic id_lvl;
  logic cpu_mbx_wr;
  logic cpu_mbx_rd;
  logic host_mbx_wr;
  logic host_mbx_rd;
  logic host_any_rd;
  logic nxt_out_full;
  logic nxt_msg1;
  logic nxt_msg2;
  logic nxt_otg_chg;
  logic otg_evt;
  logic otg_routed;

  // otg pins come from outside the clock domain
  hpmb_pin_if #(.W(2)) pin_bus ();
  assign pin_bus.raw = {vbus_above_pin, otg_id_pin};
  hpmb_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pins(pin_bus)
  );
  assign vbus_lvl = pin_bus.clean[1];
  assign id_lvl = pin_bus.clean[0];

  // cpu address decode; the status word has no cpu address at all
  always_comb begin
    unique case (cpu_addr)
      `HPMB_MBX_ADDR: cpu_tgt = TGT_MBX;
      `HPMB_MSG1_ADDR: cpu_tgt = TGT_MSG1;
      `HPMB_MSG2_ADDR: cpu_tgt = TGT_MSG2;
      default: cpu_tgt = TGT_NONE;
    endcase
  end

  // host address decode for memory cycles
  always_comb begin
    unique case (host_addr)
      `HPMB_MBX_ADDR: host_tgt = TGT_MBX;
      `HPMB_MSG1_ADDR: host_tgt = TGT_MSG1;
      `HPMB_MSG2_ADDR: host_tgt = TGT_MSG2;
      default: host_tgt = TGT_NONE;
    endcase
  end

  // access strobes
  assign cpu_mbx_wr = cpu_wr && (cpu_tgt == TGT_MBX);
  assign cpu_mbx_rd = cpu_rd && (cpu_tgt == TGT_MBX);
  assign host_mbx_wr = host_wr && (host_tgt == TGT_MBX);
  assign host_mbx_rd = host_rd && (host_tgt == TGT_MBX);
  assign host_any_rd = host_rd || host_stat_rd;

  // shared mailbox word, cpu wins a same-cycle write collision
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mbx_ff <= `HPMB_MBX_RESET;
    end else if (cpu_mbx_wr) begin
      mbx_ff <= cpu_wdata;
    end else if (host_mbx_wr) begin
      mbx_ff <= host_wdata;
    end
  end

  // incoming message flag, host write sets, cpu read clears, set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_full_ff <= 1'b0;
    end else if (host_mbx_wr) begin
      in_full_ff <= 1'b1;
    end else if (cpu_mbx_rd) begin
      in_full_ff <= 1'b0;
    end
  end

  // outgoing message flag, cpu write sets, host read clears, set wins
  assign nxt_out_full = cpu_mbx_wr | (out_full_ff & ~host_mbx_rd);

  // cpu receive interrupt, gated by its enable at the moment of the write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_irq_ff <= 1'b0;
    end else if (host_mbx_wr && mbx_rx_irq_en) begin
      rx_irq_ff <= 1'b1;
    end else if (cpu_mbx_rd) begin
      rx_irq_ff <= 1'b0;
    end
  end

  // cpu transmit interrupt, gated by its enable at the moment of the read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_irq_ff <= 1'b0;
    end else if (host_mbx_rd && mbx_tx_irq_en) begin
      tx_irq_ff <= 1'b1;
    end else if (cpu_mbx_wr) begin
      tx_irq_ff <= 1'b0;
    end
  end

  // engine message flags; any host read clears, a new write wins
  assign nxt_msg1 = (cpu_wr && (cpu_tgt == TGT_MSG1)) | (msg1_ff & ~host_any_rd);
  assign nxt_msg2 = (cpu_wr && (cpu_tgt == TGT_MSG2)) | (msg2_ff & ~host_any_rd);

  // otg level changes act as interrupts when routed
  assign otg_evt = ({vbus_lvl, id_lvl} != otg_prev_ff);
  assign otg_routed = ((vbus_lvl != otg_prev_ff[1]) && route_en[`HPMB_RT_VBUS]) ||
                      ((id_lvl != otg_prev_ff[0]) && route_en[`HPMB_RT_ID]);
  assign nxt_otg_chg = (otg_evt && otg_routed) | (otg_chg_ff & ~host_stat_rd);

  // outgoing message flag register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_full_ff <= 1'b0;
    end else begin
      out_full_ff <= nxt_out_full;
    end
  end

  // engine message one flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg1_ff <= 1'b0;
    end else begin
      msg1_ff <= nxt_msg1;
    end
  end

  // engine message two flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg2_ff <= 1'b0;
    end else begin
      msg2_ff <= nxt_msg2;
    end
  end

  // sticky cause for a routed supply or identity change, cleared by a status poll
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otg_chg_ff <= 1'b0;
    end else begin
      otg_chg_ff <= nxt_otg_chg;
    end
  end

  // last seen pin levels; reset matches the synchroniser, so no false edge after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otg_prev_ff <= 2'h0;
    end else begin
      otg_prev_ff <= {vbus_lvl, id_lvl};
    end
  end

  // routing enables mapped onto status positions
  assign route_vec = {3'h0, route_en[`HPMB_RT_FRM2], 1'b0, route_en[`HPMB_RT_FRM1],
                      route_en[9], 1'b0, route_en[7:6], 2'h0, route_en[3:1], 1'b0};
  // engine flags show only when routed to the host side
  assign eng_vis = eng_irq & route_vec & `HPMB_ENG_MASK;

  // host status word; reserved positions stay zero
  always_comb begin
    stat_word = 16'h0000;
    stat_word[`HPMB_ST_VBUS] = vbus_lvl;
    stat_word[`HPMB_ST_ID] = id_lvl;
    stat_word[`HPMB_ST_FRM2] = eng_vis[`HPMB_ST_FRM2];
    stat_word[`HPMB_ST_FRM1] = eng_vis[`HPMB_ST_FRM1];
    stat_word[`HPMB_ST_RST2] = eng_vis[`HPMB_ST_RST2];
    stat_word[`HPMB_ST_RST1] = eng_vis[`HPMB_ST_RST1];
    stat_word[`HPMB_ST_MBX_IN] = in_full_ff;
    stat_word[`HPMB_ST_WAKE2] = eng_vis[`HPMB_ST_WAKE2];
    stat_word[`HPMB_ST_WAKE1] = eng_vis[`HPMB_ST_WAKE1];
    stat_word[`HPMB_ST_MSG2] = msg2_ff;
    stat_word[`HPMB_ST_MSG1] = msg1_ff;
    stat_word[`HPMB_ST_DONE2] = eng_vis[`HPMB_ST_DONE2];
    stat_word[`HPMB_ST_DONE1] = eng_vis[`HPMB_ST_DONE1];
    stat_word[`HPMB_ST_MBX_OUT] = out_full_ff;
  end

  // host interrupt pin from next-state values so it tracks the flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intr_ff <= 1'b0;
    end else begin
      intr_ff <= nxt_out_full | nxt_msg1 | nxt_msg2 | nxt_otg_chg | (|eng_vis);
    end
  end

  // cpu read data; only the mailbox answers, the status word never does
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rdata_ff <= 16'h0000;
    end else if (cpu_rd) begin
      cpu_rdata_ff <= cpu_mbx_rd ? mbx_ff : 16'h0000;
    end
  end

  // host read data; status reads bypass the memory path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_ff <= 16'h0000;
    end else if (host_stat_rd) begin
      host_rdata_ff <= stat_word;
    end else if (host_rd) begin
      host_rdata_ff <= host_mbx_rd ? mbx_ff : 16'h0000;
    end
  end

  // memory cycle request; polling status costs the cpu nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_req_ff <= 1'b0;
    end else begin
      mem_req_ff <= (host_rd || host_wr) && !host_stat_rd;
    end
  end

  // outputs straight from flip-flops
  assign cpu_rdata = cpu_rdata_ff;
  assign host_rdata = host_rdata_ff;
  assign mbx_rx_irq = rx_irq_ff;
  assign mbx_tx_irq = tx_irq_ff;
  assign host_interrupt_pin = intr_ff;
  assign host_mem_req = mem_req_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_msg_write_flags: assert property (
    (cpu_wr && cpu_tgt == TGT_MSG1) |=> (msg1_ff && host_interrupt_pin))
    else $error("message one write did not set flag and pin");
  a_msg_read_clears: assert property (
    (msg2_ff && host_stat_rd && !(cpu_wr && cpu_tgt == TGT_MSG2)) |=> !msg2_ff)
    else $error("message two flag survived a host read");
  a_rx_irq_raise: assert property (
    (host_mbx_wr && mbx_rx_irq_en) |=> mbx_rx_irq)
    else $error("receive interrupt not raised");
  a_rx_irq_clear: assert property (
    (cpu_mbx_rd && !(host_mbx_wr && mbx_rx_irq_en)) |=> !mbx_rx_irq)
    else $error("receive interrupt not cleared by cpu read");
  a_tx_irq_raise: assert property (
    (host_mbx_rd && mbx_tx_irq_en) |=> mbx_tx_irq)
    else $error("transmit interrupt not raised");
  a_tx_irq_clear: assert property (
    (cpu_mbx_wr && !(host_mbx_rd && mbx_tx_irq_en)) |=> !mbx_tx_irq)
    else $error("transmit interrupt not cleared by cpu write");
  a_pin_mbx_out: assert property (
    cpu_mbx_wr |=> host_interrupt_pin && out_full_ff)
    else $error("cpu mailbox write did not raise pin");
  a_mbx_value: assert property (
    (host_mbx_wr && !cpu_mbx_wr) |=> (mbx_ff == $past(host_wdata)))
    else $error("mailbox missed host data");
  a_cpu_no_status: assert property (
    (cpu_rd && !cpu_mbx_rd) |=> (cpu_rdata == 16'h0000))
    else $error("cpu read returned data off the mailbox");
  a_stat_no_cycle: assert property (
    host_stat_rd |=> !host_mem_req)
    else $error("status read caused a memory cycle");
  a_stat_reserved: assert property (
    host_stat_rd |=> (host_rdata[13] == 1'b0 && host_rdata[11] == 1'b0))
    else $error("reserved status bits not zero");
  a_in_flag_set: assert property (
    host_mbx_wr |=> in_full_ff)
    else $error("incoming flag not set by host write");
  a_in_flag_read: assert property (
    (host_stat_rd && in_full_ff) |=> host_rdata[`HPMB_ST_MBX_IN])
    else $error("incoming flag not shown");
  a_unrouted_quiet: assert property (
    (route_en == 16'h0000 && eng_irq != 16'h0000 && !out_full_ff && !msg1_ff
      && !msg2_ff && !otg_chg_ff && !otg_evt)[*2] |-> !host_interrupt_pin)
    else $error("unrouted engine interrupt reached the pin");
  a_out_flag_clear: assert property (
    (host_mbx_rd && !cpu_mbx_wr) |=> !out_full_ff)
    else $error("outgoing flag survived a host mailbox read");
  // only valid when no other cause is pending, since the pin is shared
  a_pin_mbx_drop: assert property (
    (host_mbx_rd && !cpu_wr && !otg_chg_ff && !otg_evt && eng_vis == 16'h0000)
      |=> !host_interrupt_pin)
    else $error("host mailbox read left the pin raised");
  a_stat_pins: assert property (
    host_stat_rd |=> (host_rdata[`HPMB_ST_VBUS] == $past(vbus_lvl)
      && host_rdata[`HPMB_ST_ID] == $past(id_lvl)))
    else $error("status pin levels wrong");
  a_msg_vis: assert property (
    host_stat_rd |=> (host_rdata[`HPMB_ST_MSG2] == $past(msg2_ff)
      && host_rdata[`HPMB_ST_MSG1] == $past(msg1_ff)))
    else $error("message flags wrong in status word");

  c_host_to_cpu: cover property (host_mbx_wr ##[1:20] cpu_mbx_rd);
  c_cpu_to_host: cover property (cpu_mbx_wr ##[1:20] host_mbx_rd);
  c_msg_poll: cover property ((cpu_wr && cpu_tgt == TGT_MSG2) ##[1:20] host_stat_rd);
  c_set_clear_tie: cover property (cpu_mbx_wr && host_mbx_rd && out_full_ff);
  c_routed_otg: cover property (otg_chg_ff ##[1:20] host_stat_rd);
endmodule

/* File: test/hpmb_host.sv */
// behavioural external processor on the parallel host port
`timescale 1ns/100ps
module hpmb_host import hpmb_pkg::*; (
  // clock
  input wire logic clk,
  // strobes and write side
  output logic host_wr,
  output logic host_rd,
  output logic host_stat_rd,
  output logic [15:0] host_addr,
  output logic [15:0] host_wdata,
  // answer from the device
  input wire logic [15:0] host_rdata
);
  // idle bus at time zero
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_stat_rd = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
  end
  // one access: strobe for one edge, address and data held with it
  task automatic access(input logic wr, input logic rd, input logic st, input hpmb_word_t a,
      input hpmb_word_t d, output hpmb_word_t q);
    @(negedge clk);
    host_wr = wr;
    host_rd = rd;
    host_stat_rd = st;
    host_addr = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_stat_rd = 1'b0;
    // released lines flip so a stale value can never pass for a fresh one
    host_addr = ~a;
    host_wdata = ~d;
    q = host_rdata;
  endtask
  // software lets the bus supply settle before sampling its flag
  task automatic supply_settle();
    repeat (1250) @(negedge clk);
  endtask
endmodule

/* File: test/tb_hpmb.sv */
// self-checking bench for the host port mailbox and status block
`timescale 1ns/100ps
`include "hpmb_cfg.svh"
module tb_hpmb import hpmb_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic mbx_rx_irq_en = 1'b0;
  logic mbx_tx_irq_en = 1'b0;
  logic [15:0] eng_irq = 16'h0000;
  logic [15:0] route_en = 16'h0000;
  logic vbus_above_pin = 1'b0;
  logic otg_id_pin = 1'b0;
  logic [15:0] cpu_rdata;
  logic [15:0] host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic mbx_rx_irq;
  logic mbx_tx_irq;
  logic host_wr;
  logic host_rd;
  logic host_stat_rd;
  logic host_mem_req;
  logic host_interrupt_pin;
  // reference copy of mailbox, flags and cpu interrupts
  hpmb_word_t e_mbx = 16'h0000;
  logic e_out = 1'b0;
  logic e_in = 1'b0;
  logic e_m1 = 1'b0;
  logic e_m2 = 1'b0;
  logic e_rx = 1'b0;
  logic e_tx = 1'b0;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h00000049;
  logic [31:0] r;
  hpmb_word_t d;
  hpmb_word_t q;

  hpmb_top u_hpmb_top (.clk, .rst_b, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata,
    .mbx_rx_irq_en, .mbx_tx_irq_en, .mbx_rx_irq, .mbx_tx_irq, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_stat_rd, .host_rdata, .host_mem_req, .host_interrupt_pin, .eng_irq,
    .route_en, .vbus_above_pin, .otg_id_pin);
  hpmb_host u_hpmb_host (.clk, .host_wr, .host_rd, .host_stat_rd, .host_addr, .host_wdata,
    .host_rdata);

  // free running clock, 8 ns period
  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // engine routing mask in status positions; 13 and 11 stay zero
  function automatic hpmb_word_t rt();
    return {3'h0, route_en[13], 1'b0, route_en[11], route_en[9], 1'b0, route_en[7:6], 2'h0,
      route_en[3:1], 1'b0};
  endfunction
  function automatic hpmb_word_t st_exp();
    hpmb_word_t s;
    s = eng_irq & rt();
    s[15] = vbus_above_pin;
    s[14] = otg_id_pin;
    s[8] = e_in;
    s[5] = e_m2;
    s[4] = e_m1;
    s[0] = e_out;
    return s;
  endfunction
  function automatic logic pin_exp();
    return e_out | e_m1 | e_m2 | (|(eng_irq & rt()));
  endfunction
  task automatic chk(input hpmb_word_t seen, input hpmb_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one cpu strobe cycle
  task automatic cpu(input logic wr, input hpmb_word_t a, input hpmb_word_t dat);
    @(negedge clk);
    cpu_wr = wr;
    cpu_rd = ~wr;
    cpu_addr = a;
    cpu_wdata = dat;
    @(negedge clk);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = ~dat;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    end_sim();
  end

  // reset, then random operations against the reference copy
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    cpu(1'b0, `HPMB_MBX_ADDR, 16'h0000);
    chk(cpu_rdata, 16'h0000);
    // corner: live engine flags with no routing stay off pin and status
    eng_irq = 16'hFFFF;
    repeat (4) @(negedge clk);
    chk(16'(host_interrupt_pin), 16'(pin_exp()));
    d = st_exp();
    u_hpmb_host.access(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, q);
    chk(q, d);
    // corner: a routed supply change holds the pin until the host polls status
    route_en = 16'h8000;
    vbus_above_pin = 1'b1;
    u_hpmb_host.supply_settle();
    chk(16'(host_interrupt_pin), 16'h0001);
    d = st_exp();
    u_hpmb_host.access(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, q);
    chk(q, d);
    chk(16'(host_interrupt_pin), 16'(pin_exp()));
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      d = r[31:16];
      mbx_rx_irq_en = r[3];
      mbx_tx_irq_en = r[4];
      case (r[2:0])
        3'h0: begin
          cpu(1'b1, `HPMB_MBX_ADDR, d);
          e_mbx = d;
          e_out = 1'b1;
          e_tx = 1'b0;
        end
        3'h1: begin
          cpu(1'b0, `HPMB_MBX_ADDR, d);
          chk(cpu_rdata, e_mbx);
          e_in = 1'b0;
          e_rx = 1'b0;
        end
        3'h2, 3'h3: begin
          cpu(1'b1, r[0] ? `HPMB_MSG2_ADDR : `HPMB_MSG1_ADDR, d);
          e_m1 = e_m1 | ~r[0];
          e_m2 = e_m2 | r[0];
        end
        3'h4: begin
          u_hpmb_host.access(1'b1, 1'b0, 1'b0, `HPMB_MBX_ADDR, d, q);
          chk(16'(host_mem_req), 16'h0001);
          e_mbx = d;
          e_in = 1'b1;
          e_rx = e_rx | r[3];
        end
        3'h5: begin
          u_hpmb_host.access(1'b0, 1'b1, 1'b0, `HPMB_MBX_ADDR, d, q);
          chk(q, e_mbx);
          e_out = 1'b0;
          e_tx = e_tx | r[4];
          e_m1 = 1'b0;
          e_m2 = 1'b0;
        end
        3'h6: begin
          d = st_exp();
          u_hpmb_host.access(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, q);
          chk(q, d);
          chk(16'(host_mem_req), 16'h0000);
          e_m1 = 1'b0;
          e_m2 = 1'b0;
        end
        default: begin
          // routing of supply and identity stays off to keep the pin level-only
          eng_irq = d;
          route_en = {2'h0, r[15:2]};
          vbus_above_pin = r[5];
          otg_id_pin = r[6];
          u_hpmb_host.supply_settle();
        end
      endcase
      chk(16'(mbx_rx_irq), 16'(e_rx));
      chk(16'(mbx_tx_irq), 16'(e_tx));
      chk(16'(host_interrupt_pin), 16'(pin_exp()));
    end
    // status word has no cpu address: the routing address reads zero
    cpu(1'b0, 16'h0142, 16'h0000);
    chk(cpu_rdata, 16'h0000);
    end_sim();
  end
endmodule
